// ### hw/pcdb_pkg.sv
// Purpose: constants for the peripheral clock divider bank
// Assumes: one clock, the high-frequency root zero, at 200 MHz
// Notes: outputs are one-cycle clock enables, not clocks
package pcdb_pkg;
	localparam int NUM_DIV = 29;
	localparam int NUM_DEST = 54;
	localparam int NUM_BYTE = 8;
	localparam int NUM_HALF = 16;
	localparam int NUM_FRAC = 4;
	localparam int FIRST_HALF = 8;
	localparam int FIRST_FRAC = 24;
	localparam int WIDE_FLAT = 28;
	localparam logic [4:0] FLAT_NONE = 5'h1f;
	localparam logic [1:0] TYPE_BYTE = 2'h0;
	localparam logic [1:0] TYPE_HALF = 2'h1;
	localparam logic [1:0] TYPE_FRACH = 2'h2;
	localparam logic [1:0] TYPE_WIDE = 2'h3;
	localparam logic [23:0] MASK_BYTE = 24'h0000ff;
	localparam logic [23:0] MASK_HALF = 24'h00ffff;
	localparam logic [23:0] MASK_WIDE = 24'hffffff;
	localparam logic [11:0] ADDR_SMALL_CORE = 12'h000;
	localparam logic [11:0] ADDR_BIG_CORE = 12'h004;
	localparam logic [11:0] ADDR_CMD = 12'h008;
	localparam logic [11:0] ADDR_EN_STAT = 12'h00c;
	localparam logic [11:0] ADDR_WAIT_STAT = 12'h010;
	localparam logic [3:0] PAGE_CTL = 4'h1;
	localparam logic [3:0] PAGE_SEL = 4'h2;
	localparam int CTL_FRAC_LSB = 0;
	localparam int CTL_INT_LSB = 5;
	localparam int CMD_IDX_LSB = 0;
	localparam int CMD_TYPE_LSB = 8;
	localparam int CMD_AIDX_LSB = 16;
	localparam int CMD_ATYPE_LSB = 24;
	localparam int CMD_DIS_BIT = 30;
	localparam int CMD_EN_BIT = 31;
	localparam int CORE_PERI_LSB = 0;
	localparam int CORE_SLOW_LSB = 8;
	localparam int CORE_FAST_LSB = 0;
	localparam int SEL_IDX_LSB = 0;
	localparam int SEL_TYPE_LSB = 8;
	localparam logic [31:0] CMD_RESET = 32'h003f_0000;
	localparam logic [7:0] DIV_RESET = 8'h00;
endpackage

// ### hw/pcdb_top.sv
// Purpose: peripheral clock divider bank with AHB-Lite registers
// Assumes: word accesses only; hready is this slave's hreadyout
// Notes: reads take one wait state, writes none
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module pcdb_top (
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic deep_sleep,
	output logic peri_clk_en,
	output logic slow_clk_en,
	output logic fast_clk_en,
	output logic [pcdb_pkg::NUM_DEST-1:0] dest_clk_en
);
	localparam int N = pcdb_pkg::NUM_DIV;
	localparam int D = pcdb_pkg::NUM_DEST;

	// Bank position of a divider from its type code and index
	function automatic logic [4:0] flat(input logic [1:0] ty,
		input logic [5:0] idx);
		logic [4:0] f;
		f = pcdb_pkg::FLAT_NONE;
		case (ty)
		pcdb_pkg::TYPE_BYTE: begin
			if (idx < 6'(pcdb_pkg::NUM_BYTE))
				f = idx[4:0];
		end
		pcdb_pkg::TYPE_HALF: begin
			if (idx < 6'(pcdb_pkg::NUM_HALF))
				f = 5'(pcdb_pkg::FIRST_HALF) + idx[4:0];
		end
		pcdb_pkg::TYPE_FRACH: begin
			if (idx < 6'(pcdb_pkg::NUM_FRAC))
				f = 5'(pcdb_pkg::FIRST_FRAC) + idx[4:0];
		end
		pcdb_pkg::TYPE_WIDE: begin
			if (idx == 6'h00)
				f = 5'(pcdb_pkg::WIDE_FLAT);
		end
		default: f = pcdb_pkg::FLAT_NONE;
		endcase
		return f;
	endfunction

	// Integer field width per divider kind
	function automatic logic [23:0] int_mask(input int i);
		if (i < pcdb_pkg::FIRST_HALF)
			return pcdb_pkg::MASK_BYTE;
		else if (i < pcdb_pkg::WIDE_FLAT)
			return pcdb_pkg::MASK_HALF;
		else
			return pcdb_pkg::MASK_WIDE;
	endfunction

	logic [11:0] addr_r;
	logic wr_r;
	logic rd_wait_r;
	logic [31:0] hrdata_r;
	logic [7:0] peri_div_r;
	logic [7:0] slow_div_r;
	logic [7:0] fast_div_r;
	logic [31:0] cmd_r;
	logic [7:0] peri_cnt_r;
	logic [7:0] slow_cnt_r;
	logic [7:0] fast_cnt_r;
	logic peri_clk_en_r;
	logic slow_clk_en_r;
	logic fast_clk_en_r;
	logic [23:0] int_div_r [N];
	logic [4:0] frac_r [N];
	logic [23:0] cnt_r [N];
	logic [4:0] acc_r [N];
	logic [4:0] ref_r [N];
	logic [N-1:0] en_r;
	logic [N-1:0] wait_r;
	logic [N-1:0] ext_r;
	logic [7:0] sel_r [D];
	logic [D-1:0] dest_r;

	logic peri_tick;
	logic cmd_go;
	logic [4:0] cmd_tgt;
	logic [4:0] cmd_ref;
	logic ctl_hit;
	logic [4:0] ctl_idx;
	logic sel_hit;
	logic [5:0] sel_idx;
	logic [N-1:0] active;
	logic [N-1:0] last;
	logic [N-1:0] pulse;
	logic [31:0] rd_mux;
	logic [4:0] dest_src [D];

	assign hreadyout = ~rd_wait_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign peri_clk_en = peri_clk_en_r;
	assign slow_clk_en = slow_clk_en_r;
	assign fast_clk_en = fast_clk_en_r;
	assign dest_clk_en = dest_r;

	// Bus address phase capture
	always_ff @(posedge clock) begin
		if (rst) begin
			addr_r <= 12'h000;
			wr_r <= 1'b0;
			rd_wait_r <= 1'b0;
		end else if (hready) begin
			if (hsel && htrans[1]) begin
				addr_r <= haddr[11:0];
			end
			wr_r <= hsel && htrans[1] && hwrite;
			rd_wait_r <= hsel && htrans[1] && !hwrite;
		end else begin
			rd_wait_r <= 1'b0;
		end
	end

	// Read data sampled in the wait state so a write just before lands
	always_ff @(posedge clock) begin
		if (rst) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_wait_r) begin
			hrdata_r <= rd_mux;
		end
	end

	assign ctl_hit = (addr_r[11:8] == pcdb_pkg::PAGE_CTL) &&
		(addr_r[7:2] < 6'(N));
	assign ctl_idx = addr_r[6:2];
	assign sel_hit = (addr_r[11:8] == pcdb_pkg::PAGE_SEL) &&
		(addr_r[7:2] < 6'(D));
	assign sel_idx = addr_r[7:2];
	assign cmd_go = wr_r && (addr_r == pcdb_pkg::ADDR_CMD);
	assign cmd_tgt = flat(hwdata[pcdb_pkg::CMD_TYPE_LSB +: 2],
		hwdata[pcdb_pkg::CMD_IDX_LSB +: 6]);
	assign cmd_ref = flat(hwdata[pcdb_pkg::CMD_ATYPE_LSB +: 2],
		hwdata[pcdb_pkg::CMD_AIDX_LSB +: 6]);

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (addr_r == pcdb_pkg::ADDR_SMALL_CORE) begin
			rd_mux[pcdb_pkg::CORE_PERI_LSB +: 8] = peri_div_r;
			rd_mux[pcdb_pkg::CORE_SLOW_LSB +: 8] = slow_div_r;
		end else if (addr_r == pcdb_pkg::ADDR_BIG_CORE) begin
			rd_mux[pcdb_pkg::CORE_FAST_LSB +: 8] = fast_div_r;
		end else if (addr_r == pcdb_pkg::ADDR_CMD) begin
			rd_mux = cmd_r;
		end else if (addr_r == pcdb_pkg::ADDR_EN_STAT) begin
			rd_mux[N-1:0] = en_r;
		end else if (addr_r == pcdb_pkg::ADDR_WAIT_STAT) begin
			rd_mux[N-1:0] = wait_r;
		end else if (ctl_hit) begin
			rd_mux[pcdb_pkg::CTL_FRAC_LSB +: 5] = frac_r[ctl_idx];
			rd_mux[pcdb_pkg::CTL_INT_LSB +: 24] = int_div_r[ctl_idx];
		end else if (sel_hit) begin
			rd_mux[pcdb_pkg::SEL_IDX_LSB +: 6] = sel_r[sel_idx][5:0];
			rd_mux[pcdb_pkg::SEL_TYPE_LSB +: 2] = sel_r[sel_idx][7:6];
		end
	end

	// Core clock divider settings
	always_ff @(posedge clock) begin
		if (rst) begin
			peri_div_r <= pcdb_pkg::DIV_RESET;
			slow_div_r <= pcdb_pkg::DIV_RESET;
			fast_div_r <= pcdb_pkg::DIV_RESET;
		end else if (wr_r) begin
			if (addr_r == pcdb_pkg::ADDR_SMALL_CORE) begin
				peri_div_r <= hwdata[pcdb_pkg::CORE_PERI_LSB +: 8];
				slow_div_r <= hwdata[pcdb_pkg::CORE_SLOW_LSB +: 8];
			end
			if (addr_r == pcdb_pkg::ADDR_BIG_CORE) begin
				fast_div_r <= hwdata[pcdb_pkg::CORE_FAST_LSB +: 8];
			end
		end
	end

	// Last command kept for read-back; action bits are not stored
	always_ff @(posedge clock) begin
		if (rst) begin
			cmd_r <= pcdb_pkg::CMD_RESET;
		end else if (cmd_go) begin
			cmd_r <= hwdata & ~(32'h1 << pcdb_pkg::CMD_EN_BIT) &
				~(32'h1 << pcdb_pkg::CMD_DIS_BIT);
		end
	end

	// Root zero prescalers; a field of k divides by k plus one
	always_ff @(posedge clock) begin
		if (rst) begin
			peri_cnt_r <= 8'h00;
			fast_cnt_r <= 8'h00;
			peri_clk_en_r <= 1'b0;
			fast_clk_en_r <= 1'b0;
		end else begin
			peri_clk_en_r <= peri_tick;
			fast_clk_en_r <= (fast_cnt_r >= fast_div_r);
			if (peri_tick)
				peri_cnt_r <= 8'h00;
			else
				peri_cnt_r <= peri_cnt_r + 8'h01;
			if (fast_cnt_r >= fast_div_r)
				fast_cnt_r <= 8'h00;
			else
				fast_cnt_r <= fast_cnt_r + 8'h01;
		end
	end

	assign peri_tick = (peri_cnt_r >= peri_div_r);

	// Slow clock counts peripheral root ticks
	always_ff @(posedge clock) begin
		if (rst) begin
			slow_cnt_r <= 8'h00;
			slow_clk_en_r <= 1'b0;
		end else begin
			slow_clk_en_r <= peri_tick && (slow_cnt_r >= slow_div_r);
			if (peri_tick) begin
				if (slow_cnt_r >= slow_div_r)
					slow_cnt_r <= 8'h00;
				else
					slow_cnt_r <= slow_cnt_r + 8'h01;
			end
		end
	end

	// Divider control words, width trimmed to each kind
	always_ff @(posedge clock) begin
		for (int i = 0; i < N; i++) begin
			if (rst) begin
				int_div_r[i] <= 24'h000000;
				frac_r[i] <= 5'h00;
			end else if (wr_r && ctl_hit && (ctl_idx == 5'(i))) begin
				int_div_r[i] <= hwdata[pcdb_pkg::CTL_INT_LSB +: 24] &
					int_mask(i);
				if (i >= pcdb_pkg::FIRST_FRAC)
					frac_r[i] <= hwdata[pcdb_pkg::CTL_FRAC_LSB +: 5];
			end
		end
	end

	// Divider status: running, period end, output pulse
	always_comb begin
		for (int i = 0; i < N; i++) begin
			logic [24:0] len;
			logic refz;
			len = 25'h0;
			refz = 1'b1;
			if (ref_r[i] < 5'(N))
				refz = (cnt_r[ref_r[i]] == 24'h000000);
			active[i] = en_r[i] && (!wait_r[i] || refz);
			// Zero integer value acts as one to keep the period finite
			len = (int_div_r[i] == 24'h000000) ? 25'h1 :
				{1'b0, int_div_r[i]};
			len = len + {24'h000000, ext_r[i]};
			last[i] = ({1'b0, cnt_r[i]} >= len - 25'h1);
			pulse[i] = peri_tick && !deep_sleep && active[i] &&
				(cnt_r[i] == 24'h000000);
		end
	end

	// Divider counters, enable and alignment
	always_ff @(posedge clock) begin
		for (int i = 0; i < N; i++) begin
			if (rst) begin
				en_r[i] <= 1'b0;
				wait_r[i] <= 1'b0;
				ext_r[i] <= 1'b0;
				ref_r[i] <= pcdb_pkg::FLAT_NONE;
				cnt_r[i] <= 24'h000000;
				acc_r[i] <= 5'h00;
			end else if (deep_sleep) begin
				// Controls kept, counters lost as in the real retention
				cnt_r[i] <= 24'h000000;
				acc_r[i] <= 5'h00;
				ext_r[i] <= 1'b0;
				wait_r[i] <= 1'b0;
			end else if (cmd_go && (cmd_tgt == 5'(i)) &&
				hwdata[pcdb_pkg::CMD_EN_BIT]) begin
				en_r[i] <= 1'b1;
				cnt_r[i] <= 24'h000000;
				acc_r[i] <= 5'h00;
				ext_r[i] <= 1'b0;
				ref_r[i] <= cmd_ref;
				// Reference left unenabled counts as zero: starts at once
				wait_r[i] <= (cmd_ref != pcdb_pkg::FLAT_NONE) &&
					(cmd_ref != 5'(i));
			end else if (cmd_go && (cmd_tgt == 5'(i)) &&
				hwdata[pcdb_pkg::CMD_DIS_BIT]) begin
				en_r[i] <= 1'b0;
				wait_r[i] <= 1'b0;
				cnt_r[i] <= 24'h000000;
				acc_r[i] <= 5'h00;
				ext_r[i] <= 1'b0;
			end else if (peri_tick && active[i]) begin
				wait_r[i] <= 1'b0;
				if (last[i]) begin
					cnt_r[i] <= 24'h000000;
					{ext_r[i], acc_r[i]} <= {1'b0, acc_r[i]} +
						{1'b0, frac_r[i]};
				end else begin
					cnt_r[i] <= cnt_r[i] + 24'h000001;
				end
			end
		end
	end

	// Destination select words
	always_ff @(posedge clock) begin
		for (int d = 0; d < D; d++) begin
			if (rst) begin
				sel_r[d] <= 8'h00;
			end else if (wr_r && sel_hit && (sel_idx == 6'(d))) begin
				sel_r[d] <= {hwdata[pcdb_pkg::SEL_TYPE_LSB +: 2],
					hwdata[pcdb_pkg::SEL_IDX_LSB +: 6]};
			end
		end
	end

	// Bank position feeding each destination, decoded outside the flops
	always_comb begin
		for (int d = 0; d < D; d++)
			dest_src[d] = flat(sel_r[d][7:6], sel_r[d][5:0]);
	end

	// Destination enables; numbering is the select word's position
	always_ff @(posedge clock) begin
		for (int d = 0; d < D; d++) begin
			if (rst)
				dest_r[d] <= 1'b0;
			else if (dest_src[d] < 5'(N))
				dest_r[d] <= pulse[dest_src[d]];
			else
				dest_r[d] <= 1'b0;
		end
	end

endmodule // pcdb_top

// ### tb/pcdb_assertions.sv
// Purpose: port checks for the divider bank
// Assumes: one clock, sync active-high reset
// Notes: divider settings are unseen here; rates are judged in tb
`timescale 1ns/100ps
module pcdb_assertions (
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic deep_sleep,
	input wire logic peri_clk_en,
	input wire logic [pcdb_pkg::NUM_DEST-1:0] dest_clk_en
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence rd_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence wr_taken;
		hsel && hready && htrans[1] && hwrite;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	chk_read_wait: assert property (rd_taken |=> one_wait)
		else $error("read data phase not one wait");
	chk_write_nowait: assert property (wr_taken |=> hreadyout)
		else $error("write data phase stalled");
	chk_wait_cause: assert property ($fell(hreadyout) |->
		$past(hsel && hready && htrans[1] && !hwrite))
		else $error("wait state without a read");
	chk_rdata_hold: assert property ($changed(hrdata) |->
		$past(!hreadyout))
		else $error("read data moved outside a wait");
	chk_sleep_quiet: assert property (deep_sleep &&
		$past(deep_sleep) && $past(deep_sleep, 2) |-> dest_clk_en == '0)
		else $error("pulse during deep sleep");
	chk_wake_quiet: assert property ($fell(deep_sleep) &&
		$past(deep_sleep, 2) |-> dest_clk_en == '0)
		else $error("stale pulse on wake");
	chk_dest_tick: assert property (|dest_clk_en |-> peri_clk_en)
		else $error("divider pulse off a root tick");
endmodule // pcdb_assertions

// ### tb/pcdb_peri_model.sv
// Purpose: consumer model timing one destination pulse train
// Assumes: taps are one-cycle enables
// Notes: miss counts watched pulses without a reference pulse
`timescale 1ns/100ps
module pcdb_peri_model (
	input wire logic clock,
	input wire logic clr,
	input wire logic [5:0] watch,
	input wire logic [5:0] ref_sel,
	input wire logic [56:0] taps,
	output logic [15:0] n_pulse,
	output logic [15:0] n_miss,
	output logic [15:0] gap_min,
	output logic [15:0] gap_max
);
	logic [15:0] age_r;
	logic hit;
	assign hit = taps[watch];
	always_ff @(posedge clock) begin
		if (clr) begin
			n_pulse <= 16'h0000;
			n_miss <= 16'h0000;
			gap_min <= 16'hffff;
			gap_max <= 16'h0000;
			age_r <= 16'h0000;
		end else if (hit) begin
			n_pulse <= n_pulse + 16'h0001;
			age_r <= 16'h0001;
			if (n_pulse != 16'h0000 && age_r < gap_min)
				gap_min <= age_r;
			if (n_pulse != 16'h0000 && age_r > gap_max)
				gap_max <= age_r;
			if (!taps[ref_sel])
				n_miss <= n_miss + 16'h0001;
		end else
			age_r <= age_r + 16'h0001;
	end
endmodule // pcdb_peri_model

// ### tb/tb.sv
// Purpose: self-checking bench for the divider bank
// Assumes: AHB-Lite single words, hready fed from hreadyout
// Notes: rates come from the consumer model, never the design
`timescale 1ns/100ps
module tb;
	logic clock, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic deep_sleep, peri_clk_en, slow_clk_en, fast_clk_en, clr;
	logic [pcdb_pkg::NUM_DEST-1:0] dest_clk_en;
	logic [5:0] watch, ref_sel;
	logic [15:0] n_pulse, n_miss, gap_min, gap_max;
	int n_mismatch, check_count;
	int dl[10] = '{0, 12, 13, 14, 15, 22, 23, 46, 47, 53};
	int wi[4] = '{0, 8, 24, 28};
	logic [31:0] wx[4] = '{32'h1fe0, 32'h1fffe0, 32'h1fffff, 32'h1fffffff};
	assign hready = hreadyout;
	pcdb_top u_pcdb_top (.clock(clock), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .deep_sleep(deep_sleep),
		.peri_clk_en(peri_clk_en), .slow_clk_en(slow_clk_en),
		.fast_clk_en(fast_clk_en), .dest_clk_en(dest_clk_en));
	pcdb_peri_model u_pcdb_peri_model (.clock(clock), .clr(clr),
		.watch(watch), .ref_sel(ref_sel), .n_pulse(n_pulse),
		.taps({fast_clk_en, slow_clk_en, peri_clk_en, dest_clk_en}),
		.n_miss(n_miss), .gap_min(gap_min), .gap_max(gap_max));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	function automatic logic [31:0] cmd(input logic [1:0] op,
		input logic [5:0] ix, input logic [1:0] ty,
		input logic [5:0] ai, input logic [1:0] at);
		return {op, 4'h0, at, 2'h0, ai, 6'h00, ty, 2'h0, ix};
	endfunction
	function automatic logic [31:0] ctl(input int i);
		return 32'h100 + 32'(4 * i);
	endfunction
	function automatic logic [31:0] sel(input int d);
		return 32'h200 + 32'(4 * d);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// One extra edge so the last counted sample has landed
	task automatic rate(input logic [5:0] w, input logic [5:0] r,
		input int n, input logic [15:0] lo, input logic [15:0] hi);
		watch <= w;
		ref_sel <= r;
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		repeat (n + 1) @(posedge clock);
		if (hi != 16'h0) chk({gap_min, gap_max}, {lo, hi});
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		end_sim;
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} <= '0;
		rst <= 1'b1;
		{deep_sleep, clr, watch, ref_sel} <= '0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rchk(32'(pcdb_pkg::ADDR_CMD), 32'h003f0000);
		rchk(32'h0, 32'h0);
		wr(32'h300, 32'h5a5a5a5a);
		rchk(32'h300, 32'h0);
		foreach (wi[i]) begin
			wr(ctl(wi[i]), 32'hffffffff);
			rchk(ctl(wi[i]), wx[i]);
		end
		$display("test regs done");
		wr(ctl(0), 32'h60);
		wr(32'(pcdb_pkg::ADDR_CMD), cmd(2'b10, 0, 0, 63, 0));
		wr(sel(0), 32'h0);
		rate(0, 0, 60, 3, 3);
		rchk(32'(pcdb_pkg::ADDR_EN_STAT), 32'h1);
		wr(32'h0, 32'h1);
		rate(0, 0, 60, 6, 6);
		rate(54, 54, 60, 2, 2);
		wr(32'h0, 32'h0201);
		rate(55, 55, 60, 6, 6);
		wr(32'h4, 32'h3);
		rate(56, 56, 60, 4, 4);
		wr(32'h0, 32'h0);
		$display("test roots done");
		wr(ctl(24), 32'h70);
		wr(32'(pcdb_pkg::ADDR_CMD), cmd(2'b10, 0, 2, 63, 0));
		wr(sel(1), 32'h200);
		rate(1, 1, 700, 3, 4);
		chk({16'h0, n_pulse}, 32'h0000_00c8);
		wr(ctl(28), 32'ha0);
		wr(32'(pcdb_pkg::ADDR_CMD), cmd(2'b10, 0, 3, 63, 0));
		foreach (dl[i]) wr(sel(dl[i]), 32'h300);
		foreach (dl[i]) rate(6'(dl[i]), 6'(dl[i]), 30, 5, 5);
		$display("test routing done");
		wr(ctl(8), 32'h80);
		wr(32'(pcdb_pkg::ADDR_CMD), cmd(2'b10, 0, 1, 63, 0));
		wr(ctl(1), 32'h100);
		wr(32'(pcdb_pkg::ADDR_CMD), cmd(2'b10, 1, 0, 0, 1));
		wr(sel(2), 32'h100);
		wr(sel(3), 32'h1);
		rate(3, 2, 100, 8, 8);
		chk({16'h0, n_miss}, 32'h0);
		deep_sleep <= 1'b1;
		repeat (3) @(posedge clock);
		rate(3, 3, 20, 0, 0);
		chk({16'h0, n_pulse}, 32'h0);
		rchk(ctl(1), 32'h100);
		rchk(sel(3), 32'h1);
		deep_sleep <= 1'b0;
		rate(3, 2, 100, 8, 8);
		chk({16'h0, n_miss}, 32'h0);
		$display("test align done");
		wr(32'(pcdb_pkg::ADDR_CMD), cmd(2'b01, 1, 0, 63, 0));
		rate(3, 3, 40, 0, 0);
		chk({16'h0, n_pulse}, 32'h0);
		rchk(32'(pcdb_pkg::ADDR_EN_STAT), 32'h11000101);
		rchk(32'(pcdb_pkg::ADDR_CMD), 32'h003f0001);
		$display("test disable done");
		end_sim;
	end
endmodule // tb
bind pcdb_top pcdb_assertions u_pcdb_assertions (.clock(clock),
	.rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .deep_sleep(deep_sleep),
	.peri_clk_en(peri_clk_en), .dest_clk_en(dest_clk_en));
